// ### bench/ifsr_flag_regs_test.sv
// Purpose: Self-checking bench for the two interrupt flag status registers.
// Assumes: clkEn is high except in one freeze scenario; the source model drives every request line.
// Notes:   Each read notes its expected word; a monitor checks read data and flag outputs.
`timescale 1ns/1ps
module ifsr_flag_regs_test
  import ifsr_pkg::*;
;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic [REG_W-1:0] data;} ifsr_note_s;
  logic              mclk, sys_rst, clkEn, regWr, regRd, fireEn, fireSel, rdPrev;
  logic [ADDR_W-1:0] regAddr, adr;
  logic [REG_W-1:0]  regWdata, regRdata, flagStatus1, flagStatus2, req1, req2, msk, rnd;
  logic [3:0]        fireBit;
  logic [1:0]        fireLen;
  ifsr_note_s        notes[$];
  ifsr_note_s        cur;
  int                n_fail, checks, seed;

  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ifsr_src_model SRC (.mclk(mclk), .sys_rst(sys_rst), .fireEn(fireEn), .fireSel(fireSel),
    .fireBit(fireBit), .fireLen(fireLen), .req1(req1), .req2(req2));

  ifsr_flag_regs DUT (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .uart2_tx_flag_req(req1[15]), .uart2_rx_flag_req(req1[14]), .ext_irq2_flag_req(req1[13]),
    .timer5_flag_req(req1[12]), .timer4_flag_req(req1[11]), .out_compare4_flag_req(req1[10]),
    .out_compare3_flag_req(req1[9]), .dma_ch2_done_flag_req(req1[8]), .in_capture8_flag_req(req1[7]),
    .in_capture7_flag_req(req1[6]), .adc2_done_flag_req(req1[5]), .ext_irq1_flag_req(req1[4]),
    .change_notify_flag_req(req1[3]), .i2c1_master_flag_req(req1[1]), .i2c1_slave_flag_req(req1[0]),
    .timer6_flag_req(req2[15]), .dma_ch4_done_flag_req(req2[14]), .out_compare8_flag_req(req2[12]),
    .out_compare7_flag_req(req2[11]), .out_compare6_flag_req(req2[10]), .out_compare5_flag_req(req2[9]),
    .in_capture6_flag_req(req2[8]), .in_capture5_flag_req(req2[7]), .in_capture4_flag_req(req2[6]),
    .in_capture3_flag_req(req2[5]), .dma_ch3_done_flag_req(req2[4]), .can1_event_flag_req(req2[3]),
    .can1_rx_flag_req(req2[2]), .spi2_event_flag_req(req2[1]), .spi2_error_flag_req(req2[0]),
    .flagStatus1(flagStatus1), .flagStatus2(flagStatus2));

  task cmpRd(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: read data %h, expected %h", $time, got, exp);
    end
  endtask : cmpRd

  task cmpStat(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: flag output %h, expected %h", $time, got, exp);
    end
  endtask : cmpStat

  // One bus cycle; every signal is set once per edge so back-to-back calls never race.
  task cyc(input logic w, input logic r, input logic f, input logic [ADDR_W-1:0] a,
           input logic [REG_W-1:0] d, input logic [REG_W-1:0] e);
    regWr    <= w;
    regRd    <= r;
    fireEn   <= f;
    regAddr  <= a;
    regWdata <= d;
    if (r) notes.push_back('{a, e});
    @(posedge mclk);
  endtask : cyc

  task results();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Read data stands only in the cycle after the strobe; the flag output lags the cell likewise.
  always @(posedge mclk) begin
    if (rdPrev) begin
      cur = notes.pop_front();
      cmpRd(regRdata, cur.data);
      if (cur.addr === OFS_FLAG1) cmpStat(flagStatus1, cur.data);
      if (cur.addr === OFS_FLAG2) cmpStat(flagStatus2, cur.data);
    end else cmpRd(regRdata, 16'h0000);
    rdPrev <= regRd;
  end

  // Watchdog sized well beyond the few hundred cycles the sequence needs.
  initial begin
    #100000;
    n_fail++;
    results();
  end

  // Main sequence.
  initial begin
    {regWr, regRd, fireEn, fireSel, regAddr, regWdata, fireBit, fireLen} = '0;
    clkEn = 1'b1;
    sys_rst = 1'b0;
    seed = 64559;
    // A clean rising edge on reset so every flop is cleared before the first clock edge.
    #1 sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(0, 1, 0, OFS_FLAG1, 16'h0000, RESET_FLAGS);
    cyc(0, 1, 0, OFS_FLAG2, 16'h0000, RESET_FLAGS);
    cyc(1, 0, 0, OFS_FLAG1, 16'hFFFF, 16'h0000);
    cyc(1, 0, 0, OFS_FLAG2, 16'hFFFF, 16'h0000);
    cyc(1, 0, 0, 4'h7, 16'hFFFF, 16'h0000);
    cyc(0, 1, 0, OFS_FLAG1, 16'h0000, IMPL_MASK1);
    cyc(0, 1, 0, OFS_FLAG2, 16'h0000, IMPL_MASK2);
    cyc(0, 1, 0, 4'h7, 16'h0000, 16'h0000);
    // Each source in turn, with a software clear landing on its first request edge.
    for (int i = 0; i < 32; i++) begin
      adr = i[4] ? OFS_FLAG2 : OFS_FLAG1;
      msk = i[4] ? IMPL_MASK2 : IMPL_MASK1;
      fireSel <= i[4];
      fireBit <= i[3:0];
      fireLen <= 2'(($unsigned($random(seed)) % 3) + 1);
      cyc(1, 0, 1, adr, 16'h0000, 16'h0000);
      cyc(1, 0, 0, adr, 16'h0000, 16'h0000);
      repeat (2) cyc(0, 0, 0, adr, 16'h0000, 16'h0000);
      cyc(0, 1, 0, adr, 16'h0000, (16'h0001 << i[3:0]) & msk);
      cyc(1, 0, 0, adr, 16'h0000, 16'h0000);
      cyc(0, 1, 0, adr, 16'h0000, 16'h0000);
    end
    // Random words written and read back at once.
    for (int k = 0; k < 8; k++) begin
      adr = k[0] ? OFS_FLAG2 : OFS_FLAG1;
      msk = k[0] ? IMPL_MASK2 : IMPL_MASK1;
      rnd = 16'($random(seed));
      cyc(1, 0, 0, adr, rnd, 16'h0000);
      cyc(0, 1, 0, adr, 16'h0000, rnd & msk);
    end
    // A second reset in mid-run must clear every flag of the first register.
    cyc(1, 0, 0, OFS_FLAG1, 16'hFFFF, 16'h0000);
    cyc(0, 0, 0, OFS_FLAG1, 16'h0000, 16'h0000);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(0, 1, 0, OFS_FLAG1, 16'h0000, RESET_FLAGS);
    repeat (3) cyc(0, 0, 0, OFS_FLAG1, 16'h0000, 16'h0000);
    // With the enable low a write must leave every flag untouched.
    clkEn <= 1'b0;
    cyc(1, 0, 0, OFS_FLAG1, 16'hFFFF, 16'h0000);
    clkEn <= 1'b1;
    cyc(0, 1, 0, OFS_FLAG1, 16'h0000, RESET_FLAGS);
    repeat (2) cyc(0, 0, 0, OFS_FLAG1, 16'h0000, 16'h0000);
    results();
  end
endmodule : ifsr_flag_regs_test

// ### bench/ifsr_src_model.sv
// Purpose: Behavioural model of the peripheral interrupt sources.
// Assumes: One source fires at a time, chosen by register select and bit index.
// Notes:   A request may stand for one to three cycles to mimic slow sources.
`timescale 1ns/1ps
module ifsr_src_model
  import ifsr_pkg::*;
(
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Firing command from the bench.
  input  wire logic             fireEn,
  input  wire logic             fireSel,
  input  wire logic [3:0]       fireBit,
  input  wire logic [1:0]       fireLen,
  // Request lines, indexed by flag bit position.
  output logic      [REG_W-1:0] req1,
  output logic      [REG_W-1:0] req2
);
  logic [1:0] left;

  // A fired request stands for fireLen cycles, then every line drops low again.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req1 <= 16'h0000;
      req2 <= 16'h0000;
      left <= 2'h0;
    end else if (fireEn) begin
      req1 <= fireSel ? 16'h0000 : (16'h0001 << fireBit); // Only one source line rises.
      req2 <= fireSel ? (16'h0001 << fireBit) : 16'h0000;
      left <= fireLen;
    end else if (left > 2'h1) begin
      left <= left - 2'h1;
    end else begin
      req1 <= 16'h0000;
      req2 <= 16'h0000;
      left <= 2'h0;
    end
  end
endmodule : ifsr_src_model

// ### rtl/ifsr_flag_bit.sv
// Purpose: One sticky interrupt flag bit with software write access.
// Assumes: Source request and bus write are synchronous to mclk.
// Notes:   A source set beats a software clear in the same cycle.
`timescale 1ns/1ps
module ifsr_flag_bit (
  // Clock, reset and enable.
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  // Set and write controls.
  input  wire logic srcSet,
  input  wire logic swWrite,
  input  wire logic swData,
  // Latched flag.
  output logic      flag
);

  // Set has priority so that a request landing on a clear is never dropped.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (clkEn) begin
      if (srcSet) begin
        flag <= 1'b1;
      end else if (swWrite) begin
        flag <= swData;
      end
    end
  end

endmodule : ifsr_flag_bit

// ### rtl/ifsr_flag_regs.sv
// Purpose: Two 16-bit interrupt flag status registers with a simple register port.
// Assumes: Source request lines are one-cycle or level pulses synchronous to mclk.
// Notes:   Unimplemented bits read zero and drop writes; reads answer one cycle later.
//
// Behaviour
// R1: Flag reads 1 after request, else 0.
// R2: Implemented flags read/write, reset to zero.
// R3: Bit 2 and bit 13 read zero.
// R4: First register bits 15..8 source mapping.
// R5: First register bits 7..3, 1, 0 mapping.
// R6: Second register bits 15,14,12..8 mapping.
// R7: Second register bits 7..0 mapping.
// R8: Simultaneous set and clear leaves set.
`timescale 1ns/1ps
module ifsr_flag_regs
  import ifsr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // Register port.
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [REG_W-1:0]  regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [REG_W-1:0]  regRdata,
  // Source request lines, first register group.
  input  wire logic              uart2_tx_flag_req,
  input  wire logic              uart2_rx_flag_req,
  input  wire logic              ext_irq2_flag_req,
  input  wire logic              timer5_flag_req,
  input  wire logic              timer4_flag_req,
  input  wire logic              out_compare4_flag_req,
  input  wire logic              out_compare3_flag_req,
  input  wire logic              dma_ch2_done_flag_req,
  input  wire logic              in_capture8_flag_req,
  input  wire logic              in_capture7_flag_req,
  input  wire logic              adc2_done_flag_req,
  input  wire logic              ext_irq1_flag_req,
  input  wire logic              change_notify_flag_req,
  input  wire logic              i2c1_master_flag_req,
  input  wire logic              i2c1_slave_flag_req,
  // Source request lines, second register group.
  input  wire logic              timer6_flag_req,
  input  wire logic              dma_ch4_done_flag_req,
  input  wire logic              out_compare8_flag_req,
  input  wire logic              out_compare7_flag_req,
  input  wire logic              out_compare6_flag_req,
  input  wire logic              out_compare5_flag_req,
  input  wire logic              in_capture6_flag_req,
  input  wire logic              in_capture5_flag_req,
  input  wire logic              in_capture4_flag_req,
  input  wire logic              in_capture3_flag_req,
  input  wire logic              dma_ch3_done_flag_req,
  input  wire logic              can1_event_flag_req,
  input  wire logic              can1_rx_flag_req,
  input  wire logic              spi2_event_flag_req,
  input  wire logic              spi2_error_flag_req,
  // Latched flags toward the interrupt logic.
  output logic      [REG_W-1:0]  flagStatus1,
  output logic      [REG_W-1:0]  flagStatus2
);

  logic [REG_W-1:0] setVec1;
  logic [REG_W-1:0] setVec2;
  logic [REG_W-1:0] flagQ1;
  logic [REG_W-1:0] flagQ2;
  logic             wrSel1;
  logic             wrSel2;
  logic [REG_W-1:0] next_rdata;

  // R4 source mapping high byte.
  // Gather the request lines into per-position vectors of the first register.
  always_comb begin
    setVec1                   = RESET_FLAGS;
    setVec1[B1_UART2_TX]      = uart2_tx_flag_req;
    setVec1[B1_UART2_RX]      = uart2_rx_flag_req;
    setVec1[B1_EXT_IRQ2]      = ext_irq2_flag_req;
    setVec1[B1_TIMER5]        = timer5_flag_req;
    setVec1[B1_TIMER4]        = timer4_flag_req;
    setVec1[B1_OUT_COMPARE4]  = out_compare4_flag_req;
    setVec1[B1_OUT_COMPARE3]  = out_compare3_flag_req;
    setVec1[B1_DMA_CH2_DONE]  = dma_ch2_done_flag_req;
    // R5 source mapping low byte.
    setVec1[B1_IN_CAPTURE8]   = in_capture8_flag_req;
    setVec1[B1_IN_CAPTURE7]   = in_capture7_flag_req;
    setVec1[B1_ADC2_DONE]     = adc2_done_flag_req;
    setVec1[B1_EXT_IRQ1]      = ext_irq1_flag_req;
    setVec1[B1_CHANGE_NOTIFY] = change_notify_flag_req;
    setVec1[B1_I2C1_MASTER]   = i2c1_master_flag_req;
    setVec1[B1_I2C1_SLAVE]    = i2c1_slave_flag_req;
  end

  // R6 source mapping high byte.
  // Same gathering for the second register.
  always_comb begin
    setVec2                   = RESET_FLAGS;
    setVec2[B2_TIMER6]        = timer6_flag_req;
    setVec2[B2_DMA_CH4_DONE]  = dma_ch4_done_flag_req;
    setVec2[B2_OUT_COMPARE8]  = out_compare8_flag_req;
    setVec2[B2_OUT_COMPARE7]  = out_compare7_flag_req;
    setVec2[B2_OUT_COMPARE6]  = out_compare6_flag_req;
    setVec2[B2_OUT_COMPARE5]  = out_compare5_flag_req;
    setVec2[B2_IN_CAPTURE6]   = in_capture6_flag_req;
    // R7 source mapping low byte.
    setVec2[B2_IN_CAPTURE5]   = in_capture5_flag_req;
    setVec2[B2_IN_CAPTURE4]   = in_capture4_flag_req;
    setVec2[B2_IN_CAPTURE3]   = in_capture3_flag_req;
    setVec2[B2_DMA_CH3_DONE]  = dma_ch3_done_flag_req;
    setVec2[B2_CAN1_EVENT]    = can1_event_flag_req;
    setVec2[B2_CAN1_RX]       = can1_rx_flag_req;
    setVec2[B2_SPI2_EVENT]    = spi2_event_flag_req;
    setVec2[B2_SPI2_ERROR]    = spi2_error_flag_req;
  end

  // Address decode for writes.
  assign wrSel1 = regWr && (regAddr == OFS_FLAG1);
  assign wrSel2 = regWr && (regAddr == OFS_FLAG2);

  // R2 flag storage per bit.
  // One flag cell per implemented position; unimplemented ones are constant zero.
  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi++) begin : g_bits
      if (IMPL_MASK1[gi]) begin : g_f1
        ifsr_flag_bit u_flag1 (
          .mclk    (mclk),
          .sys_rst (sys_rst),
          .clkEn   (clkEn),
          .srcSet  (setVec1[gi]),
          .swWrite (wrSel1),
          .swData  (regWdata[gi]),
          .flag    (flagQ1[gi])
        );
      end else begin : g_u1
        // R3 reads as zero.
        assign flagQ1[gi] = 1'b0;
      end
      if (IMPL_MASK2[gi]) begin : g_f2
        ifsr_flag_bit u_flag2 (
          .mclk    (mclk),
          .sys_rst (sys_rst),
          .clkEn   (clkEn),
          .srcSet  (setVec2[gi]),
          .swWrite (wrSel2),
          .swData  (regWdata[gi]),
          .flag    (flagQ2[gi])
        );
      end else begin : g_u2
        // R3 reads as zero.
        assign flagQ2[gi] = 1'b0;
      end
    end
  endgenerate

  // R1 read mux.
  // Unmapped addresses read zero so software never sees stale data.
  always_comb begin
    if (regAddr == OFS_FLAG1) begin
      next_rdata = flagQ1;
    end else if (regAddr == OFS_FLAG2) begin
      next_rdata = flagQ2;
    end else begin
      next_rdata = RESET_FLAGS;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= RESET_FLAGS;
    end else if (clkEn) begin
      regRdata <= regRd ? next_rdata : RESET_FLAGS;
    end
  end

  // Registered copy of the flags so outputs come straight from flip-flops.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flagStatus1 <= RESET_FLAGS;
      flagStatus2 <= RESET_FLAGS;
    end else if (clkEn) begin
      flagStatus1 <= flagQ1;
      flagStatus2 <= flagQ2;
    end
  end

  // R8 set beats clear.
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    (clkEn && wrSel1 && !regWdata[B1_TIMER4] && timer4_flag_req) |=> flagQ1[B1_TIMER4])
    else $error("Timer4 request lost against a clear.");

  // R1 request sets flag.
  AST_REQ_SETS: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    (clkEn && spi2_error_flag_req) |=> flagQ2[B2_SPI2_ERROR])
    else $error("SPI2 error request did not set its flag.");

  // R1 flag holds without cause.
  AST_FLAG_STABLE: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    (!wrSel2 && setVec2 == RESET_FLAGS) |=> flagQ2 == $past(flagQ2))
    else $error("Second register changed without request or write.");

  // R3 unimplemented zero.
  // Each spare position is checked only on a read of its own register, since the same bit is live in the other.
  AST_UNIMPL_ZERO: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    (clkEn && regRd && regAddr == OFS_FLAG1) |=> (regRdata[B1_UNUSED] == 1'b0))
    else $error("Unimplemented bit of the first register read as one.");

  // R3 unimplemented zero.
  AST_UNIMPL_ZERO2: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    (clkEn && regRd && regAddr == OFS_FLAG2) |=> (regRdata[B2_UNUSED] == 1'b0))
    else $error("Unimplemented bit of the second register read as one.");

  // R2 write then read back.
  AST_WRITE_READ: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    (clkEn && wrSel1 && setVec1 == RESET_FLAGS) |=> flagQ1 == ($past(regWdata) & IMPL_MASK1))
    else $error("First register write not stored.");

  // R4 mapping check.
  AST_UART2_TX: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    (clkEn && uart2_tx_flag_req) ##1 clkEn |=> flagStatus1[B1_UART2_TX])
    else $error("UART2 transmit flag not at bit 15.");

  // R5 mapping check.
  AST_I2C1_SLAVE: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (clkEn && i2c1_slave_flag_req) ##1 clkEn |=> flagStatus1[B1_I2C1_SLAVE])
    else $error("I2C1 slave flag not at bit 0.");

  // R6 mapping check.
  AST_TIMER6: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    (clkEn && timer6_flag_req) ##1 clkEn |=> flagStatus2[B2_TIMER6])
    else $error("Timer6 flag not at bit 15.");

  // R7 mapping check.
  AST_CAN1_RX: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (clkEn && regRd && regAddr == OFS_FLAG2 && flagQ2[B2_CAN1_RX]) |=> regRdata[B2_CAN1_RX])
    else $error("CAN1 receive flag not read at bit 2.");

endmodule : ifsr_flag_regs

// ### rtl/ifsr_pkg.sv
// Purpose: Constants for the two interrupt flag status registers.
// Assumes: Register offsets are not given, so two word indexes are chosen here.
// Notes:   Bit positions follow the register layouts and index the source vectors.
package ifsr_pkg;

  // Register addressing.
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_FLAG1    = 4'h0;
  localparam logic [3:0]  OFS_FLAG2    = 4'h1;
  localparam int          REG_W        = 16;

  // Implemented bit masks; a zero marks an unimplemented position.
  localparam logic [15:0] IMPL_MASK1   = 16'hFFFB;
  localparam logic [15:0] IMPL_MASK2   = 16'hDFFF;
  localparam logic [15:0] RESET_FLAGS  = 16'h0000;

  // First register bit positions.
  localparam int B1_UART2_TX      = 15;
  localparam int B1_UART2_RX      = 14;
  localparam int B1_EXT_IRQ2      = 13;
  localparam int B1_TIMER5        = 12;
  localparam int B1_TIMER4        = 11;
  localparam int B1_OUT_COMPARE4  = 10;
  localparam int B1_OUT_COMPARE3  = 9;
  localparam int B1_DMA_CH2_DONE  = 8;
  localparam int B1_IN_CAPTURE8   = 7;
  localparam int B1_IN_CAPTURE7   = 6;
  localparam int B1_ADC2_DONE     = 5;
  localparam int B1_EXT_IRQ1      = 4;
  localparam int B1_CHANGE_NOTIFY = 3;
  localparam int B1_UNUSED        = 2;
  localparam int B1_I2C1_MASTER   = 1;
  localparam int B1_I2C1_SLAVE    = 0;

  // Second register bit positions.
  localparam int B2_TIMER6        = 15;
  localparam int B2_DMA_CH4_DONE  = 14;
  localparam int B2_UNUSED        = 13;
  localparam int B2_OUT_COMPARE8  = 12;
  localparam int B2_OUT_COMPARE7  = 11;
  localparam int B2_OUT_COMPARE6  = 10;
  localparam int B2_OUT_COMPARE5  = 9;
  localparam int B2_IN_CAPTURE6   = 8;
  localparam int B2_IN_CAPTURE5   = 7;
  localparam int B2_IN_CAPTURE4   = 6;
  localparam int B2_IN_CAPTURE3   = 5;
  localparam int B2_DMA_CH3_DONE  = 4;
  localparam int B2_CAN1_EVENT    = 3;
  localparam int B2_CAN1_RX       = 2;
  localparam int B2_SPI2_EVENT    = 1;
  localparam int B2_SPI2_ERROR    = 0;

endpackage : ifsr_pkg
